// ==== src/sup_pkg.sv ====
// Package: constants and carrier types for the supply supervisor
package sup_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned STRETCH_MS     = 200;
  localparam int unsigned CE_HOLD_US     = 10;
  localparam int unsigned WDOG_MS        = 1600;
  localparam int unsigned STRETCH_CYC    = (CLK_HZ / 1000) * STRETCH_MS;
  localparam int unsigned CE_HOLD_CYC    = (CLK_HZ / 1000000) * CE_HOLD_US;
  localparam int unsigned WDOG_CYC       = (CLK_HZ / 1000) * WDOG_MS;
  localparam int unsigned CNT_W          = 26;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic        RST_N_INIT     = 1'b0;
  localparam logic        CE_OUT_INIT    = 1'b1;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic above_reset;
    logic above_switch;
    logic above_battery;
    logic battery_good;
    logic powerfail_ok;
    logic above_early;
  } sup_cmp_t;

  typedef struct packed {
    logic supply_from_backup;
    logic backup_selected;
    logic battery_good_flag;
    logic powerfail_flag_n;
    logic early_supply_warning_n;
    logic watchdog_fault_n;
  } sup_stat_t;

endpackage : sup_pkg

// ==== src/sup_sync.sv ====
// Module: two-flop synchroniser for a group of pins
`timescale 1ns/10ps
`default_nettype none
module sup_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d_in;
    q_d    = meta_q;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= meta_d;
      q_out  <= q_d;
    end
  end
endmodule : sup_sync
`default_nettype wire

// ==== src/sup_top.sv ====
// Module: supply supervisor logic (reset, switchover, flags, watchdog, CE gating)
// Operation
// - RAM supply from main when main above reset threshold or battery.
// - RAM supply from battery when main below switchover and battery.
// - Battery-good high when battery good, low when main below switchover.
// - Power-fail flag low if sense low or main below switchover.
// - Power-fail pin is also an input; forcing low helps freshness seal.
// - Backup-selected indicator follows the RAM supply source.
// - Manual reset low asserts reset for as long as held.
// - Reset low on low supply or manual reset, then 200ms stretch.
// - Watchdog fault low after timeout without kick; high on next kick.
// - Watchdog fault high between thresholds, low below switchover.
// - Gated chip select low only when input low and either not in reset or within the hold that starts when reset asserts.
// - Chip select held low up to 10us after reset if input low.
// - Active-high reset is the inverse of active-low reset.
// - Early warning low when main falls to the early threshold.
// - Watchdog timeout is nominally 1.6 seconds.
// - Watchdog timer cleared while in reset, counts after release or kick.
// - Stretch timer restarts whenever main drops below reset threshold.
// - First half of stretch ignores manual reset if power-fail pin forced low.
`timescale 1ns/10ps
`default_nettype none
module sup_top #(
  parameter int unsigned STRETCH_CYC = sup_pkg::STRETCH_CYC,
  parameter int unsigned WDOG_CYC    = sup_pkg::WDOG_CYC,
  parameter int unsigned CE_CYC      = sup_pkg::CE_HOLD_CYC
) (
  input  wire logic              clock_in,
  input  wire logic              nrst_in,
  input  wire sup_pkg::sup_cmp_t cmp_in,
  input  wire logic              manual_reset_n_in,
  input  wire logic              watchdog_kick_in,
  input  wire logic              powerfail_flag_n_in,
  input  wire logic              chip_select_n_in,
  output var  logic              powerfail_flag_n_out,
  output var  logic              powerfail_flag_n_oe_out,
  output var  sup_pkg::sup_stat_t stat_out,
  output var  logic              reset_n_out,
  output var  logic              reset_out,
  output var  logic              chip_select_n_out
);
  localparam int W = sup_pkg::CNT_W;

  // ==========================================================
  // Pin synchronisation
  // ==========================================================
  sup_pkg::sup_cmp_t cmp_s;
  logic [3:0]        pin_s;
  logic              mr_n_s, kick_s, pf_pin_s, cs_n_s;

  sup_sync #(.W(6)) u_sync_cmp (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .d_in     (cmp_in),
    .q_out    (cmp_s)
  );
  sup_sync #(.W(4)) u_sync_pin (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .d_in     ({manual_reset_n_in, watchdog_kick_in, powerfail_flag_n_in, chip_select_n_in}),
    .q_out    (pin_s)
  );
  assign {mr_n_s, kick_s, pf_pin_s, cs_n_s} = pin_s;

  // ==========================================================
  // Supply selection and flags
  // ==========================================================
  logic src_backup_q, src_backup_d;
  logic pf_n, pf_forced;
  sup_pkg::sup_stat_t stat_d;

  always_comb begin
    src_backup_d = src_backup_q;
    if (cmp_s.above_reset || cmp_s.above_battery) begin
      src_backup_d = 1'b0;
    end else if (!cmp_s.above_switch && !cmp_s.above_battery) begin
      src_backup_d = 1'b1;
    end
  end
  assign pf_n      = cmp_s.powerfail_ok && cmp_s.above_switch;
  assign pf_forced = pf_n && !pf_pin_s;

  // ==========================================================
  // Reset stretch
  // ==========================================================
  logic [W-1:0] rst_cnt_q, rst_cnt_d;
  logic         rst_n_q, rst_n_d;
  logic         mr_active;

  always_comb begin
    mr_active = !mr_n_s;
    if (!rst_n_q && rst_cnt_q < W'(STRETCH_CYC / 2) && pf_forced) begin
      mr_active = 1'b0;
    end
    rst_cnt_d = rst_cnt_q;
    rst_n_d   = rst_n_q;
    if (!cmp_s.above_reset || mr_active) begin
      rst_cnt_d = '0;
      rst_n_d   = 1'b0;
    end else if (!rst_n_q) begin
      if (rst_cnt_q >= W'(STRETCH_CYC - 1)) begin
        rst_n_d = 1'b1;
      end else begin
        rst_cnt_d = rst_cnt_q + W'(1);
      end
    end
  end

  // ==========================================================
  // Watchdog
  // ==========================================================
  logic [W-1:0] wd_cnt_q, wd_cnt_d;
  logic         wd_fault_q, wd_fault_d;
  logic         kick_prev_q, wd_n;

  always_comb begin
    wd_cnt_d   = wd_cnt_q;
    wd_fault_d = wd_fault_q;
    if (!rst_n_q || kick_s != kick_prev_q) begin
      wd_cnt_d   = '0;
      wd_fault_d = 1'b0;
    end else if (wd_cnt_q >= W'(WDOG_CYC - 1)) begin
      wd_fault_d = 1'b1;
    end else begin
      wd_cnt_d = wd_cnt_q + W'(1);
    end
  end
  assign wd_n = cmp_s.above_switch && !wd_fault_q;

  // ==========================================================
  // Chip-enable gating
  // ==========================================================
  logic [W-1:0] ce_cnt_q, ce_cnt_d;
  logic         ce_hold_q, ce_hold_d;
  logic         cs_q, cs_d;

  always_comb begin
    ce_cnt_d  = ce_cnt_q;
    ce_hold_d = ce_hold_q;
    if (rst_n_q && !rst_n_d) begin
      ce_hold_d = !cs_n_s;
      ce_cnt_d  = '0;
    end else if (ce_hold_q) begin
      if (cs_n_s || ce_cnt_q >= W'(CE_CYC - 1)) begin
        ce_hold_d = 1'b0;
      end else begin
        ce_cnt_d = ce_cnt_q + W'(1);
      end
    end
    cs_d = !(!cs_n_s && (rst_n_d || ce_hold_d));
  end

  always_comb begin
    stat_d.supply_from_backup     = src_backup_d;
    stat_d.backup_selected        = src_backup_d;
    stat_d.battery_good_flag      = cmp_s.battery_good && cmp_s.above_switch;
    stat_d.powerfail_flag_n       = pf_n;
    stat_d.early_supply_warning_n = cmp_s.above_early;
    stat_d.watchdog_fault_n       = wd_n;
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_backup_q      <= 1'b0;
      rst_cnt_q         <= '0;
      rst_n_q           <= sup_pkg::RST_N_INIT;
      wd_cnt_q          <= '0;
      wd_fault_q        <= 1'b0;
      kick_prev_q       <= 1'b0;
      ce_cnt_q          <= '0;
      ce_hold_q         <= 1'b0;
      cs_q              <= sup_pkg::CE_OUT_INIT;
      stat_out          <= '0;
    end else begin
      src_backup_q      <= src_backup_d;
      rst_cnt_q         <= rst_cnt_d;
      rst_n_q           <= rst_n_d;
      wd_cnt_q          <= wd_cnt_d;
      wd_fault_q        <= wd_fault_d;
      kick_prev_q       <= kick_s;
      ce_cnt_q          <= ce_cnt_d;
      ce_hold_q         <= ce_hold_d;
      cs_q              <= cs_d;
      stat_out          <= stat_d;
    end
  end

  // Open-drain style flag pin: drive low only
  assign powerfail_flag_n_out    = 1'b0;
  assign powerfail_flag_n_oe_out = !stat_out.powerfail_flag_n;
  assign reset_n_out             = rst_n_q;
  assign reset_out               = !rst_n_q;
  assign chip_select_n_out       = cs_q;
endmodule : sup_top
`default_nettype wire

// ==== sim/sup_top_assertions.sv ====
// Checker: port-level assertions for the supply supervisor
`timescale 1ns/10ps
`default_nettype none
module sup_top_assertions #(
  parameter int unsigned STRETCH_CYC = 40
) (
  input wire logic              clock_in,
  input wire logic              nrst_in,
  input wire sup_pkg::sup_cmp_t cmp_in,
  input wire logic              manual_reset_n_in,
  input wire logic              chip_select_n_in,
  input wire logic              powerfail_flag_n_oe_out,
  input wire sup_pkg::sup_stat_t stat_out,
  input wire logic              reset_n_out,
  input wire logic              reset_out,
  input wire logic              chip_select_n_out
);
  // ==========
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  int unsigned low_q;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) low_q <= 0;
    else low_q <= reset_n_out ? 0 : low_q + 1;
  end
  chk_reset_inverse: assert property (reset_out == !reset_n_out)
    else $error("reset outputs not inverse");
  chk_manual_hold: assert property (!manual_reset_n_in [*4] |-> !reset_n_out)
    else $error("reset high during manual reset");
  chk_supply_low: assert property (!cmp_in.above_reset [*4] |-> !reset_n_out)
    else $error("reset high with low supply");
  chk_stretch_len: assert property ($rose(reset_n_out) |-> low_q >= STRETCH_CYC)
    else $error("reset stretch too short");
  chk_ce_blocked: assert property (!reset_n_out [*8] |-> chip_select_n_out)
    else $error("chip select low in reset");
  chk_ce_idle: assert property (chip_select_n_in [*4] |-> chip_select_n_out)
    else $error("chip select low without request");
  chk_backup_ind: assert property (stat_out.backup_selected == stat_out.supply_from_backup)
    else $error("backup indicator mismatch");
  chk_pf_flag: assert property (!cmp_in.powerfail_ok [*4] |-> !stat_out.powerfail_flag_n)
    else $error("power-fail flag high");
  chk_pf_drive: assert property (powerfail_flag_n_oe_out == !stat_out.powerfail_flag_n)
    else $error("power-fail pin drive mismatch");
  chk_below_switch: assert property (!cmp_in.above_switch [*4] |->
    !stat_out.battery_good_flag && !stat_out.watchdog_fault_n)
    else $error("flags high below switchover");
  cov_release: cover property ($rose(reset_n_out));
  cov_wdog: cover property ($fell(stat_out.watchdog_fault_n));
  cov_ce_hold: cover property ($fell(reset_n_out) && !chip_select_n_out);
endmodule : sup_top_assertions
bind sup_top sup_top_assertions #(.STRETCH_CYC(STRETCH_CYC)) u_chk (.clock_in(clock_in),
  .nrst_in(nrst_in), .cmp_in(cmp_in), .manual_reset_n_in(manual_reset_n_in),
  .chip_select_n_in(chip_select_n_in), .powerfail_flag_n_oe_out(powerfail_flag_n_oe_out),
  .stat_out(stat_out), .reset_n_out(reset_n_out), .reset_out(reset_out),
  .chip_select_n_out(chip_select_n_out));
`default_nettype wire

// ==== sim/sup_host_model.sv ====
// Partner: host kick source and power-fail pin wiring
`timescale 1ns/10ps
`default_nettype none
module sup_host_model (
  input  wire logic clock_in,
  input  wire logic kick_en_in,
  input  wire logic force_pf_low_in,
  input  wire logic pf_oe_in,
  output var  logic kick_out,
  output var  logic pf_pin_out
);
  initial kick_out = 1'b0;
  always @(posedge clock_in) begin
    if (kick_en_in) kick_out <= #2 ~kick_out;
  end
  assign pf_pin_out = !(pf_oe_in || force_pf_low_in); // Pull-up pin
endmodule : sup_host_model
`default_nettype wire

// ==== sim/sup_top_tb.sv ====
// Testbench: directed checks of the supply supervisor
`timescale 1ns/10ps
`default_nettype none
module sup_top_tb;
  logic              clock_in = 1'b0;
  logic              nrst_in = 1'b0;
  sup_pkg::sup_cmp_t cmp = 6'h3f;
  logic              mr_n = 1'b1, cs_n = 1'b1, kick_en = 1'b0, force_pf = 1'b0;
  logic              kick, pf_pin, pf_d, pf_oe, rst_n, rst, cs_out;
  sup_pkg::sup_stat_t st;
  int                bad_count = 0, tests_run = 0, cyc = 0;
  sup_top #(.STRETCH_CYC(40), .WDOG_CYC(100), .CE_CYC(5)) dut (.clock_in(clock_in),
    .nrst_in(nrst_in), .cmp_in(cmp), .manual_reset_n_in(mr_n), .watchdog_kick_in(kick),
    .powerfail_flag_n_in(pf_pin), .chip_select_n_in(cs_n), .powerfail_flag_n_out(pf_d),
    .powerfail_flag_n_oe_out(pf_oe), .stat_out(st), .reset_n_out(rst_n),
    .reset_out(rst), .chip_select_n_out(cs_out));
  sup_host_model host (.clock_in(clock_in), .kick_en_in(kick_en), .force_pf_low_in(force_pf),
    .pf_oe_in(pf_oe), .kick_out(kick), .pf_pin_out(pf_pin));
  // ==========
  // Tasks
  initial forever #25 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask : step
  task automatic chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // ==========
  // Sequence
  initial begin
    step(20);
    nrst_in = 1'b1;
    kick_en = 1'b1;
    step(30); chk(rst_n, 1'b0);
    step(20); chk(rst_n, 1'b1);
    chk(rst, 1'b0);
    chk(st.backup_selected, 1'b0);
    chk(st.battery_good_flag, 1'b1);
    chk(st.powerfail_flag_n, 1'b1);
    chk(st.early_supply_warning_n, 1'b1);
    cs_n = 1'b0;
    step(4); chk(cs_out, 1'b0);
    mr_n = 1'b0;
    step(4); chk(rst_n, 1'b0);
    chk(cs_out, 1'b0);
    step(8); chk(cs_out, 1'b1);
    mr_n = 1'b1;
    cs_n = 1'b1;
    step(30); chk(rst_n, 1'b0);
    step(20); chk(rst_n, 1'b1);
    step(120); chk(st.watchdog_fault_n, 1'b1);
    kick_en = 1'b0;
    step(90); chk(st.watchdog_fault_n, 1'b1);
    step(20); chk(st.watchdog_fault_n, 1'b0);
    kick_en = 1'b1;
    step(6); chk(st.watchdog_fault_n, 1'b1);
    cmp.powerfail_ok = 1'b0;
    step(4); chk(pf_pin, 1'b0);
    cmp.powerfail_ok = 1'b1;
    cmp.above_early = 1'b0;
    step(4); chk(st.early_supply_warning_n, 1'b0);
    chk(rst_n, 1'b1);
    cmp = 6'h04;
    step(4); chk(rst_n, 1'b0);
    chk(st.backup_selected, 1'b1);
    chk(st.battery_good_flag, 1'b0);
    chk(st.watchdog_fault_n, 1'b0);
    cmp = 6'h3f;
    step(4); chk(st.backup_selected, 1'b0);
    step(26);
    cmp.above_reset = 1'b0;
    step(4); cmp.above_reset = 1'b1;
    step(30); chk(rst_n, 1'b0);
    step(20); chk(rst_n, 1'b1);
    cmp.above_reset = 1'b0;
    force_pf = 1'b1;
    step(4); cmp.above_reset = 1'b1;
    step(10); mr_n = 1'b0;
    step(4); mr_n = 1'b1;
    step(16); chk(rst_n, 1'b0);
    step(16); chk(rst_n, 1'b1);
    force_pf = 1'b0;
    report_and_stop();
  end
endmodule : sup_top_tb
`default_nettype wire
